// *** cmc_consts.svh ***
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH

// matrix geometry and serial word layout
`define CMC_NUM_OUT       16
`define CMC_GRP_BITS      6
`define CMC_FULL_BITS     96
`define CMC_IND_BITS      16
`define CMC_IND_CHIP_MSB  13
`define CMC_IND_CHIP_LSB  10
`define CMC_IND_OUT_MSB   9
`define CMC_IND_OUT_LSB   6

// timing
`define CMC_CLK_NS        10
`define CMC_POR_HOLD_NS   40
`define CMC_POR_HOLD_CYC  ((`CMC_POR_HOLD_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)

// register map, byte addresses
`define CMC_REG_CTRL      8'h00
`define CMC_REG_STAT      8'h04
`define CMC_REG_IDX       8'h08
`define CMC_REG_CFG       8'h0c
`define CMC_CTRL_PULL_BIT 0
`define CMC_CTRL_UPD_BIT  1
`define CMC_CTRL_RST      1'h0
`define CMC_IDX_RST       4'h0

`endif

// *** cmc_pkg.sv ***
package cmc_pkg;

   // one applied control latch: en at bit 5, gain at bit 4, input at 3..0
   typedef struct packed {
      logic       en;
      logic       gain2;
      logic [3:0] input_sel;
   } cmc_cfg_t;

   // serial link pins, synchronised together so their skew stays equal
   typedef struct packed {
      logic sclk;
      logic din;
      logic sel_n;
      logic update;
      logic mode;
   } cmc_link_t;

   // slow status pins
   typedef struct packed {
      logic       line;
      logic       por_below;
      logic       hot;
      logic [3:0] strap;
   } cmc_sense_t;

endpackage : cmc_pkg

// *** cmc_sync.sv ***
`timescale 1ns/100ps
module cmc_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         en_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] q_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         q_q    <= '0;
      end else if (en_i) begin
         meta_q <= d_i;
         q_q    <= meta_q;
      end
   end

   assign q_o = q_q;

endmodule : cmc_sync

// *** cmc_edge.sv ***
`timescale 1ns/100ps
module cmc_edge #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         en_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] fall_o
);

   logic [W-1:0] prev_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_q <= '0;
      end else if (en_i) begin
         prev_q <= d_i;
      end
   end

   // pulses only count while the clock enable is high
   assign rise_o = {W{en_i}} & d_i & ~prev_q;
   assign fall_o = {W{en_i}} & ~d_i & prev_q;

endmodule : cmc_edge

// *** cmc_ctl.sv ***
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
`include "cmc_consts.svh"
module cmc_ctl #(
   parameter int unsigned NUM_OUT = `CMC_NUM_OUT
) (
   input  wire logic                              CLK_I,
   input  wire logic                              RESETN_I,
   input  wire logic                              CLK_EN_I,
   input  wire logic [7:0]                        ADR_I,
   input  wire logic [31:0]                       DAT_I,
   output logic      [31:0]                       DAT_O,
   input  wire logic [3:0]                        SEL_I,
   input  wire logic                              WE_I,
   input  wire logic                              CYC_I,
   input  wire logic                              STB_I,
   output logic                                   ACK_O,
   input  wire logic                              SCLK_I,
   input  wire logic                              DIN_I,
   input  wire logic                              LINK_SEL_N_I,
   input  wire logic                              UPDATE_I,
   input  wire logic                              MODE_I,
   output logic                                   DOUT_O,
   input  wire logic [3:0]                        CHIP_ADDRESS_STRAP_I,
   input  wire logic                              RST_LINE_I,
   output logic                                   RST_LINE_O,
   output logic                                   RST_LINE_OE_O,
   input  wire logic                              POR_BELOW_I,
   input  wire logic                              THERM_HOT_I,
   input  wire logic [NUM_OUT-1:0]                OVERLAY_KEY_I,
   output logic      [NUM_OUT-1:0]                OVERLAY_FILL_SEL_O,
   output cmc_pkg::cmc_cfg_t [NUM_OUT-1:0]        OUT_CFG_O
);

   localparam int unsigned FULL = NUM_OUT * `CMC_GRP_BITS;
   localparam int unsigned IND  = `CMC_IND_BITS;
   localparam logic [2:0]  POR_HOLD = 3'(`CMC_POR_HOLD_CYC);

   cmc_pkg::cmc_link_t               link_raw;
   cmc_pkg::cmc_link_t               link_s;
   cmc_pkg::cmc_sense_t              sense_raw;
   cmc_pkg::cmc_sense_t              sense_s;
   logic              [1:0]          edge_rise;
   logic              [1:0]          edge_fall;
   logic                             sclk_rise;
   logic                             upd_fall;
   logic                             shift_en;
   logic                             apply;
   logic                             addr_match;
   logic              [FULL-1:0]     sreg_q;
   logic              [IND-1:0]      ind_q;
   logic                             dirty_q;
   cmc_pkg::cmc_cfg_t [NUM_OUT-1:0]  latch_q;
   cmc_pkg::cmc_cfg_t [NUM_OUT-1:0]  out_q;
   logic              [NUM_OUT-1:0]  latch_en;
   logic              [NUM_OUT-1:0]  out_en;
   logic              [NUM_OUT*5-1:0] latch_keep;
   logic                             dout_q;
   logic              [2:0]          por_cnt_q;
   logic                             por_pull;
   logic                             pull_oe_q;
   logic                             swpull_q;
   logic                             swupd_q;
   logic              [3:0]          idx_q;
   logic                             ack_q;
   logic              [31:0]         dat_q;
   logic              [31:0]         rd_d;
   logic                             wb_take;

   // picks the 6-bit group of one output from the full-matrix word
   function automatic cmc_pkg::cmc_cfg_t grp_of(input logic [FULL-1:0] v,
                                                input int unsigned     idx);
      grp_of = v[idx * `CMC_GRP_BITS +: `CMC_GRP_BITS];
   endfunction : grp_of

   // pins in struct field order, so each group shares one synchroniser
   assign link_raw  = {SCLK_I, DIN_I, LINK_SEL_N_I, UPDATE_I, MODE_I};
   assign sense_raw = {RST_LINE_I, POR_BELOW_I, THERM_HOT_I, CHIP_ADDRESS_STRAP_I};

   cmc_sync #(
      .W ($bits(cmc_pkg::cmc_link_t))
   ) u_link_sync (
      .clk_i   (CLK_I),
      .rst_n_i (RESETN_I),
      .en_i    (CLK_EN_I),
      .d_i     (link_raw),
      .q_o     (link_s)
   );

   // line reads low during reset, so the enables start cleared
   cmc_sync #(
      .W ($bits(cmc_pkg::cmc_sense_t))
   ) u_sense_sync (
      .clk_i   (CLK_I),
      .rst_n_i (RESETN_I),
      .en_i    (CLK_EN_I),
      .d_i     (sense_raw),
      .q_o     (sense_s)
   );

   cmc_edge #(
      .W (2)
   ) u_edge (
      .clk_i   (CLK_I),
      .rst_n_i (RESETN_I),
      .en_i    (CLK_EN_I),
      .d_i     ({link_s.sclk, link_s.update}),
      .rise_o  (edge_rise),
      .fall_o  (edge_fall)
   );

   assign sclk_rise = edge_rise[1];
   assign shift_en  = sclk_rise & ~link_s.sel_n;
   assign upd_fall  = edge_fall[0];
   assign apply     = (upd_fall | swupd_q) & CLK_EN_I;

   assign addr_match = ind_q[`CMC_IND_CHIP_MSB:`CMC_IND_CHIP_LSB] == sense_s.strap;

   // msb first: the first group shifted travels furthest down the chain
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sreg_q <= '0;
         ind_q  <= '0;
      end else if (CLK_EN_I && shift_en) begin
         if (link_s.mode) begin
            sreg_q <= {sreg_q[FULL-2:0], link_s.din};
         end else begin
            ind_q <= {ind_q[IND-2:0], link_s.din};
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         dirty_q <= 1'b0;
      end else if (CLK_EN_I) begin
         if (shift_en && link_s.mode) begin
            dirty_q <= 1'b1;
         end else if (!sense_s.line) begin
            dirty_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         dout_q <= 1'b0;
      end else if (CLK_EN_I) begin
         dout_q <= link_s.mode ? sreg_q[FULL-1] : link_s.din;
      end
   end

   assign DOUT_O = dout_q;

   // the shift register is never cleared by the line, so an update after
   // a reset with no new data restores the previous settings
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         latch_q <= '0;
      end else if (CLK_EN_I) begin
         for (int unsigned i = 0; i < NUM_OUT; i++) begin
            if (apply && link_s.mode) begin
               latch_q[i] <= grp_of(sreg_q, i);
            end else if (apply && !link_s.mode && addr_match &&
                         ind_q[`CMC_IND_OUT_MSB:`CMC_IND_OUT_LSB] == 4'(i)) begin
               latch_q[i] <= ind_q[`CMC_GRP_BITS-1:0];
            end
            if (!sense_s.line) begin
               latch_q[i].en <= 1'b0;
            end
         end
      end
   end

   // outputs forced off while line low
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         out_q <= '0;
      end else if (CLK_EN_I) begin
         for (int unsigned i = 0; i < NUM_OUT; i++) begin
            out_q[i]    <= latch_q[i];
            out_q[i].en <= latch_q[i].en & sense_s.line;
         end
      end
   end

   assign OUT_CFG_O = out_q;

   assign OVERLAY_FILL_SEL_O = ~OVERLAY_KEY_I;

   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g++) begin : g_view
         assign latch_en[g]           = latch_q[g].en;
         assign out_en[g]             = out_q[g].en;
         assign latch_keep[g*5 +: 5]  = {latch_q[g].gain2, latch_q[g].input_sel};
      end
   endgenerate

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         por_cnt_q <= POR_HOLD;
      end else if (CLK_EN_I) begin
         if (sense_s.por_below) begin
            por_cnt_q <= POR_HOLD;
         end else if (por_cnt_q != 3'h0) begin
            por_cnt_q <= por_cnt_q - 3'h1;
         end
      end
   end

   assign por_pull = sense_s.por_below | (por_cnt_q != 3'h0);

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pull_oe_q <= 1'b1;
      end else if (CLK_EN_I) begin
         pull_oe_q <= por_pull | sense_s.hot | swpull_q;
      end
   end

   // open drain: only ever drives low
   assign RST_LINE_O    = 1'b0;
   assign RST_LINE_OE_O = pull_oe_q;

   assign wb_take = CYC_I & STB_I & ~ack_q;

   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (ADR_I)
         `CMC_REG_CTRL: rd_d = {31'h0, swpull_q};
         `CMC_REG_STAT: rd_d = {23'h0, dirty_q, sense_s.strap, link_s.mode,
                                sense_s.hot, por_pull, sense_s.line};
         `CMC_REG_IDX:  rd_d = {28'h0, idx_q};
         `CMC_REG_CFG:  rd_d = {26'h0, latch_q[idx_q]};
         default:       rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else if (CLK_EN_I) begin
         ack_q <= wb_take;
         if (wb_take && !WE_I) begin
            dat_q <= rd_d;
         end
      end
   end

   // software update is a one-cycle pulse; software pull is a level
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         swpull_q <= `CMC_CTRL_RST;
         swupd_q  <= 1'b0;
         idx_q    <= `CMC_IDX_RST;
      end else if (CLK_EN_I) begin
         swupd_q <= 1'b0;
         if (wb_take && WE_I && SEL_I[0]) begin
            if (ADR_I == `CMC_REG_CTRL) begin
               swpull_q <= DAT_I[`CMC_CTRL_PULL_BIT];
               swupd_q  <= DAT_I[`CMC_CTRL_UPD_BIT];
            end
            if (ADR_I == `CMC_REG_IDX) begin
               idx_q <= DAT_I[3:0];
            end
         end
      end
   end

   assign ACK_O = ack_q;
   assign DAT_O = dat_q;

   line_off_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (!sense_s.line && CLK_EN_I) |=> (out_en == '0))
      else $error("output enabled while reset line low");

   en_follow_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (sense_s.line && CLK_EN_I) |=> (out_en == $past(latch_en)))
      else $error("output enable does not follow latch");

   keep_sel_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (!sense_s.line && !apply) |=> $stable(latch_keep) && (latch_en == '0))
      else $error("line reset disturbed select or gain");

   full_load_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (apply && link_s.mode && sense_s.line) |=>
         (latch_q[NUM_OUT-1] == $past(sreg_q[FULL-1 -: 6]))
         && (latch_q[0] == $past(sreg_q[5:0])))
      else $error("full-matrix word not applied in order");

   addr_miss_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (apply && !link_s.mode && !addr_match && sense_s.line) |=> $stable(latch_q))
      else $error("individual word acted on wrong chip");

   key_inert_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      ($changed(OVERLAY_KEY_I) && !apply && sense_s.line) |=> $stable(latch_q))
      else $error("overlay key changed stored settings");

   dout_pass_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (CLK_EN_I && !link_s.mode) |=> (DOUT_O == $past(link_s.din)))
      else $error("serial pass-through broken");

   dout_chain_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (CLK_EN_I && link_s.mode) |=> (DOUT_O == $past(sreg_q[FULL-1])))
      else $error("chain output not from shift register end");

   por_hold_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I || !CLK_EN_I)
      $fell(sense_s.por_below) |-> por_pull [*4] ##1 !por_pull)
      else $error("power-on hold not four cycles");

   therm_pull_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (sense_s.hot && CLK_EN_I) |=> RST_LINE_OE_O)
      else $error("thermal event did not pull reset line");

endmodule : cmc_ctl

// *** cmc_host_model.sv ***
`timescale 1ns/100ps
module cmc_host_model (
   input  wire logic          clk_i,
   output cmc_pkg::cmc_link_t link_o,
   output logic [15:0]        key_o
);
   cmc_pkg::cmc_link_t link_q;
   logic [15:0]        key_q;

   assign link_o = link_q;
   assign key_o  = key_q;

   initial begin
      link_q = '{sclk: 1'b0, din: 1'b0, sel_n: 1'b1, update: 1'b0, mode: 1'b1};
      key_q  = 16'hffff;
   end

   task automatic set_mode(input logic m);
      link_q.mode <= m;
      @(posedge clk_i);
   endtask : set_mode

   task automatic send(input logic [95:0] w, input int nbits);
      int i;
      link_q.sel_n <= 1'b0;
      for (i = nbits - 1; i >= 0; i--) begin
         link_q.din <= w[i];
         // low phase alternates 6 and 7 cycles to average a 125 ns period
         repeat (6 + i % 2) @(posedge clk_i);
         link_q.sclk <= 1'b1;
         repeat (6) @(posedge clk_i);
         link_q.sclk <= 1'b0;
      end
      repeat (6) @(posedge clk_i);
      link_q.sel_n <= 1'b1;
      // released data line must not keep looking valid
      link_q.din   <= ~w[0];
      @(posedge clk_i);
   endtask : send

   task automatic pulse_update;
      link_q.update <= 1'b1;
      repeat (6) @(posedge clk_i);
      link_q.update <= 1'b0;
      @(posedge clk_i);
   endtask : pulse_update

   task automatic set_keys(input logic [15:0] k);
      key_q <= k;
   endtask : set_keys
endmodule : cmc_host_model

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic [7:0]         adr = 8'h00;
   logic [31:0]        dat_w = 32'h0;
   logic [3:0]         sel = 4'h0;
   logic               we = 1'b0;
   logic               cyc = 1'b0;
   logic               stb = 1'b0;
   logic [3:0]         strap = 4'h9;
   logic               ext_pull = 1'b0;
   logic               por = 1'b0;
   logic               hot = 1'b0;
   logic               clk_en = 1'b1;
   wire logic          line_o;
   wire logic [31:0]   dat_r;
   wire logic          ack;
   wire logic          dout;
   wire logic          oe;
   wire logic          line_lvl;
   wire logic [15:0]   keys;
   wire logic [15:0]   fill_sel;
   wire logic [95:0]   cfg;
   cmc_pkg::cmc_link_t link;
   int                 fails = 0;
   int                 check_count = 0;
   logic [95:0]        word;
   logic [95:0]        enm;
   logic [95:0]        exp0;
   logic [31:0]        q;

   always #5 clk = ~clk;

   // open-drain reset wire with pull-up
   assign line_lvl = ~ext_pull & (oe ? line_o : 1'b1);

   cmc_host_model host (.clk_i(clk), .link_o(link), .key_o(keys));

   cmc_ctl dut (
      .CLK_I(clk), .RESETN_I(rst_n), .CLK_EN_I(clk_en), .ADR_I(adr), .DAT_I(dat_w),
      .DAT_O(dat_r), .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
      .SCLK_I(link.sclk), .DIN_I(link.din), .LINK_SEL_N_I(link.sel_n),
      .UPDATE_I(link.update), .MODE_I(link.mode), .DOUT_O(dout),
      .CHIP_ADDRESS_STRAP_I(strap), .RST_LINE_I(line_lvl), .RST_LINE_O(line_o),
      .RST_LINE_OE_O(oe), .POR_BELOW_I(por), .THERM_HOT_I(hot),
      .OVERLAY_KEY_I(keys), .OVERLAY_FILL_SEL_O(fill_sel), .OUT_CFG_O(cfg)
   );

   task automatic tally_and_finish;
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
      int n;
      adr   <= a;
      we    <= w;
      dat_w <= d;
      sel   <= s;
      cyc   <= 1'b1;
      stb   <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         fails++;
         tally_and_finish();
      end
      r = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic wait_cfg(input logic [95:0] exp);
      int n;
      n = 0;
      while (cfg !== exp && n < 60) begin
         @(posedge clk);
         n++;
      end
      check(cfg, exp);
      if (cfg !== exp) tally_and_finish();
   endtask : wait_cfg

   task automatic wait_oe(input logic v);
      int n;
      n = 0;
      while (oe !== v && n < 60) begin
         @(posedge clk);
         n++;
      end
      check(oe, v);
      if (oe !== v) tally_and_finish();
   endtask : wait_oe

   initial begin
      for (int i = 0; i < 16; i++) begin
         word[6*i +: 6] = {1'b1, i[0], 4'(15 - i)};
         enm[6*i +: 6]  = 6'h20;
      end
      exp0 = word & ~enm;
      exp0[23:18] = 6'h27;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check(oe, 1'b1);
      wait_oe(1'b0);
      check(cfg, 96'h0);
      repeat (5) @(posedge clk);
      wb(8'h00, 1'b0, 32'h0, 4'hf, q);
      check(q, 32'h0);
      wb(8'h10, 1'b0, 32'h0, 4'hf, q);
      check(q, 32'h0);
      wb(8'h08, 1'b1, 32'h5, 4'h0, q);
      wb(8'h08, 1'b0, 32'h0, 4'hf, q);
      check(q, 32'h0);
      wb(8'h08, 1'b1, 32'h5, 4'h1, q);
      wb(8'h08, 1'b0, 32'h0, 4'hf, q);
      check(q, 32'h5);
      // full matrix load, applied only on the strobe's falling edge
      host.set_mode(1'b1);
      host.send(word, 96);
      repeat (4) @(posedge clk);
      check(cfg, 96'h0);
      check(dout, word[95]);
      host.pulse_update();
      wait_cfg(word);
      wb(8'h0c, 1'b0, 32'h0, 4'hf, q);
      check(q, {26'h0, word[35:30]});
      // overlay keys switch without a clock and leave settings alone
      host.set_keys(16'h5a3c);
      #1;
      check(fill_sel, 16'ha5c3);
      @(posedge clk);
      host.set_keys(16'h00ff);
      #1;
      check(fill_sel, 16'hff00);
      repeat (3) @(posedge clk);
      check(cfg, word);
      ext_pull <= 1'b1;
      wait_cfg(word & ~enm);
      ext_pull <= 1'b0;
      repeat (20) @(posedge clk);
      check(cfg, word & ~enm);
      host.pulse_update();
      wait_cfg(word);
      hot <= 1'b1;
      wait_oe(1'b1);
      wait_cfg(word & ~enm);
      hot <= 1'b0;
      wait_oe(1'b0);
      repeat (10) @(posedge clk);
      check(cfg, word & ~enm);
      por <= 1'b1;
      wait_oe(1'b1);
      por <= 1'b0;
      repeat (4) @(posedge clk);
      check(oe, 1'b1);
      wait_oe(1'b0);
      wb(8'h00, 1'b1, 32'h1, 4'h1, q);
      wait_oe(1'b1);
      wb(8'h00, 1'b1, 32'h0, 4'h1, q);
      wait_oe(1'b0);
      repeat (5) @(posedge clk);
      // status: line high, mode 1, strap 9, no pulls, no new data
      wb(8'h04, 1'b0, 32'h0, 4'hf, q);
      check(q, 32'h99);
      // lone device, so its enabled outputs never share a column
      // individual words: only the strapped chip address acts
      host.set_mode(1'b0);
      host.send({80'h0, 2'b00, 4'h9, 4'h3, 1'b1, 1'b0, 4'h7}, 16);
      host.pulse_update();
      wait_cfg(exp0);
      host.send({80'h0, 2'b00, 4'h4, 4'h2, 1'b1, 1'b1, 4'h1}, 16);
      host.pulse_update();
      repeat (10) @(posedge clk);
      check(cfg, exp0);
      check(dout, link.din);
      // software update in full-matrix mode reapplies the unchanged word
      host.set_mode(1'b1);
      repeat (2) @(posedge clk);
      wb(8'h00, 1'b1, 32'h2, 4'h1, q);
      wait_cfg(word);
      // clock enable low freezes line sampling and the latches
      clk_en   <= 1'b0;
      ext_pull <= 1'b1;
      repeat (10) @(posedge clk);
      check(cfg, word);
      check(oe, 1'b0);
      ext_pull <= 1'b0;
      repeat (2) @(posedge clk);
      clk_en <= 1'b1;
      repeat (10) @(posedge clk);
      check(cfg, word);
      tally_and_finish();
   end
endmodule : tb
